// ===== shared/sram_host_consts.vh
// Timing and geometry constants of the battery-backed memory host port
`ifndef SRAM_HOST_CONSTS_VH
`define SRAM_HOST_CONSTS_VH
`define CLK_PERIOD_NS        10
`define ADDR_WIDTH           11
`define DATA_WIDTH           8
`define ADDR_ACCESS_NS       70
`define SELECT_ACCESS_NS     70
`define GATE_ACCESS_NS       35
`define FLOAT_TIME_NS        25
`define OUTPUT_HOLD_NS       10
`define WRITE_FLOAT_NS       25
`define RECOVERY_NS          10
`define DATA_SETUP_NS        30
`define DATA_HOLD_NS         5
`define WRITE_PULSE_NS       50
`define ADDR_TO_WEND_NS      60
`define ROUND_UP(t)          (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC        `ROUND_UP(`ADDR_ACCESS_NS)
`define FLOAT_WAIT_CYC       `ROUND_UP(`FLOAT_TIME_NS)
`define RECOVERY_CYC         `ROUND_UP(`RECOVERY_NS)
`define WRITE_LOW_CYC        `ROUND_UP(`ADDR_TO_WEND_NS)
`define DATA_HOLD_CYC        `ROUND_UP(`DATA_HOLD_NS)
`define SYNC_WAIT_CYC        2
`define CNT_WIDTH            4
`endif

// ===== rtl/cycle_timer.v
// Down-counter that paces each phase of a memory cycle
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
	parameter WIDTH = 4
) (
	input  wire             sysClk,
	input  wire             rstN,
	input  wire             clkEn,
	input  wire             load,
	input  wire [WIDTH-1:0] loadVal,
	output wire             done
);
	reg [WIDTH-1:0] count_r;

	// Load a phase length, then count down to zero
	always @(posedge sysClk) begin
		if (!rstN) begin
			count_r <= {WIDTH{1'b0}};
		end else if (clkEn) begin
			if (load) begin
				count_r <= loadVal;
			end else if (count_r != {WIDTH{1'b0}}) begin
				count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	// Zero count ends the phase; load stays out of it so no loop forms with the caller
	assign done = (count_r == {WIDTH{1'b0}});
endmodule // cycle_timer
`default_nettype wire

// ===== rtl/sram_host_port.v
// Host controller that drives the battery-backed byte memory through its pins
//
// Behaviour
// - Host keeps address stable through write.
// - Host returns controls high for recovery time.
// - Host meets data setup and hold.
// - Host holds gate high during writes.
// - Host holds strobe low for pulse width.
// - Host gives address early before strobe rises.
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_consts.vh"
module sram_host_port #(
	parameter AW = `ADDR_WIDTH,
	parameter DW = `DATA_WIDTH
) (
	input  wire          sys_clk,
	input  wire          rst_n,
	input  wire          clkEn,
	input  wire          reqValid,
	input  wire          reqWrite,
	input  wire [AW-1:0] reqAddr,
	input  wire [DW-1:0] reqWdata,
	output wire          reqReady,
	output reg           rspValid,
	output reg  [DW-1:0] rspRdata,
	output reg  [AW-1:0] byteAddress,
	output reg           selectN,
	output reg           gateN,
	output reg           strobeN,
	input  wire [DW-1:0] dataPinsIn,
	output reg  [DW-1:0] dataPinsOut,
	output reg           dataPinsOeN
);
	////////////////////////////////////////////////////////////////////////
	localparam [6:0] IDLE  = 7'h01;
	localparam [6:0] RWAIT = 7'h02;
	localparam [6:0] RFLT  = 7'h04;
	localparam [6:0] WLOW  = 7'h08;
	localparam [6:0] WHOLD = 7'h10;
	localparam [6:0] RECOV = 7'h20;
	localparam [6:0] RSTAT = 7'h40;

	// Phase lengths as integers, then cut to the timer width on purpose
	localparam integer READ_INT  = `READ_WAIT_CYC;
	localparam integer FLT_INT   = `FLOAT_WAIT_CYC;
	localparam integer WLOW_INT  = `WRITE_LOW_CYC;
	localparam integer HOLD_INT  = `DATA_HOLD_CYC;
	localparam integer RECOV_INT = `RECOVERY_CYC;
	localparam integer SYNC_INT  = `SYNC_WAIT_CYC;

	localparam [`CNT_WIDTH-1:0] READ_CYC  = READ_INT[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] FLT_CYC   = FLT_INT[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] WLOW_CYC  = WLOW_INT[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] HOLD_CYC  = HOLD_INT[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] RECOV_CYC = RECOV_INT[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] SYNC_CYC  = SYNC_INT[`CNT_WIDTH-1:0];

	reg  [6:0]            state_r;
	reg  [6:0]            state_nxt;
	reg                   load;
	reg  [`CNT_WIDTH-1:0] loadVal;
	wire                  done;
	reg  [DW-1:0]         syncA_r;
	reg  [DW-1:0]         syncB_r;
	reg  [DW-1:0]         syncC_r;

	////////////////////////////////////////////////////////////////////////
	// Phase timer
	cycle_timer #(.WIDTH(`CNT_WIDTH)) uTimer (
		.sysClk  (sys_clk),
		.rstN    (rst_n),
		.clkEn   (clkEn),
		.load    (load),
		.loadVal (loadVal),
		.done    (done)
	);

	// Three-stage capture of the asynchronous data pins
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			syncA_r <= {DW{1'b0}};
			syncB_r <= {DW{1'b0}};
			syncC_r <= {DW{1'b0}};
		end else if (clkEn) begin
			syncA_r <= dataPinsIn;
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	assign reqReady = (state_r == IDLE);

	////////////////////////////////////////////////////////////////////////
	// Next state and timer loads
	always @* begin
		state_nxt = state_r;
		load      = 1'b0;
		loadVal   = {`CNT_WIDTH{1'b0}};
		case (state_r)
			IDLE: begin
				if (reqValid) begin
					load = 1'b1;
					if (reqWrite) begin
						state_nxt = WLOW;
						loadVal   = WLOW_CYC;
					end else begin
						state_nxt = RWAIT;
						loadVal   = READ_CYC;
					end
				end
			end
			RWAIT: begin
				// Wait two more cycles so the last two sync stages see settled data
				if (done) begin
					state_nxt = RSTAT;
					load      = 1'b1;
					loadVal   = SYNC_CYC;
				end
			end
			RSTAT: begin
				if (done && syncB_r == syncC_r) begin
					state_nxt = RFLT;
					load      = 1'b1;
					loadVal   = FLT_CYC;
				end
			end
			RFLT: begin
				if (done) begin
					state_nxt = RECOV;
					load      = 1'b1;
					loadVal   = RECOV_CYC;
				end
			end
			WLOW: begin
				if (done) begin
					state_nxt = WHOLD;
					load      = 1'b1;
					loadVal   = HOLD_CYC;
				end
			end
			WHOLD: begin
				if (done) begin
					state_nxt = RECOV;
					load      = 1'b1;
					loadVal   = RECOV_CYC;
				end
			end
			RECOV: begin
				if (done) begin
					state_nxt = IDLE;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive and answer registers
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r     <= IDLE;
			byteAddress <= {AW{1'b0}};
			selectN     <= 1'b1;
			gateN       <= 1'b1;
			strobeN     <= 1'b1;
			dataPinsOut <= {DW{1'b0}};
			dataPinsOeN <= 1'b1;
			rspValid    <= 1'b0;
			rspRdata    <= {DW{1'b0}};
		end else if (clkEn) begin
			state_r  <= state_nxt;
			rspValid <= 1'b0;
			case (state_nxt)
				RWAIT: begin
					if (state_r == IDLE) begin
						byteAddress <= reqAddr;
					end
					selectN <= 1'b0;
					gateN   <= 1'b0;
					strobeN <= 1'b1;
				end
				WLOW: begin
					if (state_r == IDLE) begin
						byteAddress <= reqAddr;
						dataPinsOut <= reqWdata;
					end
					// Select and strobe fall together, gate stays high
					selectN     <= 1'b0;
					strobeN     <= 1'b0;
					gateN       <= 1'b1;
					dataPinsOeN <= 1'b0;
				end
				WHOLD: begin
					// Both rise together; data and address stay put
					selectN <= 1'b1;
					strobeN <= 1'b1;
				end
				RFLT: begin
					if (state_r == RSTAT) begin
						rspRdata <= syncC_r;
						rspValid <= 1'b1;
					end
					selectN <= 1'b1;
					gateN   <= 1'b1;
				end
				RECOV: begin
					selectN     <= 1'b1;
					strobeN     <= 1'b1;
					gateN       <= 1'b1;
					dataPinsOeN <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end
endmodule // sram_host_port
`default_nettype wire

// ===== bench/sram_host_port_assertions.sv
// Pin protocol checker for the memory host port
`timescale 1ns/100ps
`default_nettype none
module sram_host_port_assertions #(
	parameter AW = 11,
	parameter DW = 8
) (
	input wire logic          sys_clk,
	input wire logic          rst_n,
	input wire logic          clkEn,
	input wire logic          rspValid,
	input wire logic [AW-1:0] byteAddress,
	input wire logic          selectN,
	input wire logic          gateN,
	input wire logic          strobeN,
	input wire logic [DW-1:0] dataPinsOut,
	input wire logic          dataPinsOeN
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_write_mode: assert property (!strobeN |-> !selectN && gateN)
		else $error("strobe low without select or with gate low");
	a_gate_drive: assert property (!dataPinsOeN |-> gateN)
		else $error("host drives pins while gate low");
	a_strobe_width: assert property ($fell(strobeN) |-> !strobeN [*5])
		else $error("strobe pulse too short");
	a_addr_hold: assert property (!strobeN |=> $stable(byteAddress))
		else $error("address moved in write");
	a_data_setup: assert property ($rose(strobeN) |->
		$past(dataPinsOut, 3) == dataPinsOut && !dataPinsOeN)
		else $error("write data setup or hold broken");
	a_recovery: assert property ($rose(selectN) |=> selectN)
		else $error("select recovery too short");
	a_read_wait: assert property ($fell(gateN) |-> (!gateN && !selectN) [*8])
		else $error("read ended before access time");
	a_float_wait: assert property ($rose(gateN) |-> dataPinsOeN [*3])
		else $error("host drove pins before float time");
	a_rsp_pulse: assert property (rspValid && clkEn |=> !rspValid)
		else $error("response longer than one cycle");
endmodule // sram_host_port_assertions
bind sram_host_port sram_host_port_assertions #(.AW(AW), .DW(DW)) chk (.*);
`default_nettype wire

// ===== bench/bbsram_model.sv
// Behavioural model of the battery-backed byte memory
`timescale 1ns/100ps
`default_nettype none
module bbsram_model (
	input wire logic [10:0] byteAddress,
	input wire logic        selectN,
	input wire logic        gateN,
	input wire logic        strobeN,
	input wire logic [7:0]  dataPinsOut,
	input wire logic        dataPinsOeN,
	input wire logic        powerFail,
	input wire logic        batteryWeak,
	output wire logic [7:0] dataPinsIn
);
	logic [7:0] mem [0:2047];
	logic [7:0] junk = 8'h00;
	logic       lowFlag = 1'b0;
	logic       settled = 1'b0;
	time        tChg = 0;
	wire        rdEn = !powerFail && !selectN && !gateN && strobeN;
	// Access restarts on any address or control move
	always @(byteAddress, selectN, gateN, strobeN, powerFail) tChg = $time;
	always #1 settled = rdEn && ($time - tChg >= 70);
	always #7 junk = junk + 8'h3D;
	// Pin level: host drive, settled byte, or a changing floating value
	assign dataPinsIn = !dataPinsOeN ? dataPinsOut : settled ? mem[byteAddress] : junk;
	// Write ends at the earlier rising edge of select or strobe
	always @(posedge (selectN | strobeN))
		if (!powerFail) begin
			if (lowFlag) lowFlag = 1'b0;
			else mem[byteAddress] = dataPinsIn;
		end
	always @(negedge powerFail) lowFlag = batteryWeak;
endmodule // bbsram_model
`default_nettype wire

// ===== bench/tb_sram_host_port.sv
// Self-checking bench for the memory host port
`timescale 1ns/100ps
`default_nettype none
module tb_sram_host_port;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clkEn = 1'b1;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [10:0] reqAddr = 11'h000;
	logic [7:0]  reqWdata = 8'h00;
	logic [7:0]  rspRdata, dataPinsOut, dataPinsIn, rd;
	logic [10:0] byteAddress;
	logic        reqReady, rspValid, selectN, gateN, strobeN, dataPinsOeN;
	logic        powerFail = 1'b1, batteryWeak = 1'b0, slow = 1'b0;
	int          err_count = 0, compares = 0, n;
	always #5 sys_clk = ~sys_clk;
	// Clock enable drops one cycle in three in slow mode
	always @(posedge sys_clk) clkEn <= #1 !(slow && ($time / 10) % 3 == 0);
	sram_host_port dut (.*);
	bbsram_model mem (.*);
	task automatic tally_and_finish;
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic hang(input logic ok);
		if (!ok) begin
			err_count++;
			$display("CHECK FAILED handshake exp 1 got 0");
			tally_and_finish;
		end
	endtask
	task automatic waitReady;
		n = 0;
		while (reqReady !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			#1 n++;
		end
		hang(n < 200);
	endtask
	// One request, held until taken at an enabled edge
	task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
		waitReady;
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWdata = d;
		do @(posedge sys_clk); while (clkEn !== 1'b1);
		#1 reqValid = 1'b0;
		n = 0;
		while (!w && rspValid !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			#1 n++;
		end
		hang(n < 200);
		rd = rspRdata;
	endtask
	task automatic rdchk(input logic [10:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		compares++;
		if (rd !== e) begin
			err_count++;
			$display("CHECK FAILED rspRdata exp %h got %h", e, rd);
		end
	endtask
	task automatic t_corners;
		xfer(1'b1, 11'h000, 8'hA5);
		xfer(1'b1, 11'h7FF, 8'h5A);
		xfer(1'b1, 11'h2AA, 8'hC3);
		rdchk(11'h000, 8'hA5);
		rdchk(11'h7FF, 8'h5A);
		rdchk(11'h2AA, 8'hC3);
	endtask
	// Power returns with a weak battery: first write is lost
	task automatic t_battery;
		powerFail = 1'b1;
		batteryWeak = 1'b1;
		#50 powerFail = 1'b0;
		xfer(1'b1, 11'h2AA, 8'h11);
		rdchk(11'h2AA, 8'hC3);
		xfer(1'b1, 11'h2AA, 8'h22);
		rdchk(11'h2AA, 8'h22);
	endtask
	task automatic t_pfail;
		powerFail = 1'b1;
		batteryWeak = 1'b0;
		xfer(1'b1, 11'h7FF, 8'hEE);
		xfer(1'b1, 11'h000, 8'hEE);
		waitReady;
		powerFail = 1'b0;
		rdchk(11'h7FF, 8'h5A);
		rdchk(11'h000, 8'hA5);
		rdchk(11'h2AA, 8'h22);
	endtask
	task automatic t_slow;
		slow = 1'b1;
		xfer(1'b1, 11'h155, 8'h3C);
		rdchk(11'h155, 8'h3C);
		slow = 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		powerFail = 1'b0;
		t_corners;
		t_battery;
		t_pfail;
		t_slow;
		tally_and_finish;
	end
endmodule // tb_sram_host_port
`default_nettype wire
